//--- iovr_params.svh
// Field positions, reset value and codes of the input overvoltage reaction byte
`ifndef IOVR_PARAMS_SVH
`define IOVR_PARAMS_SVH
`define IOVR_RESP_POS      6
`define IOVR_RETRY_POS     3
`define IOVR_DELAY_POS     0
`define IOVR_REACTION_RST  8'h00
`define IOVR_RETRY_NONE    3'h0
`define IOVR_RETRY_FOREVER 3'h7
`endif

//--- iovr_pkg.sv
// Types of the input overvoltage fault reaction block
package iovr_pkg;
  typedef enum logic [1:0] {
    IOVR_IGNORE   = 2'b00,
    IOVR_RIDE     = 2'b01,
    IOVR_RETRY    = 2'b10,
    IOVR_LATCHOFF = 2'b11
  } iovr_resp_t;

  typedef enum logic [2:0] {
    IOVR_ST_RUN     = 3'b000,
    IOVR_ST_RIDE    = 3'b001,
    IOVR_ST_OFFWAIT = 3'b010,
    IOVR_ST_ATTEMPT = 3'b011,
    IOVR_ST_LATCHED = 3'b100
  } iovr_state_t;
endpackage

//--- iovr_delay_timer.sv
// Delay timer counting 2**code time units of unitCycles clocks each
`timescale 1ns/1ps
module iovr_delay_timer #(
  parameter int UNIT_W = 16
) (
  input  wire logic              mclk,
  input  wire logic              rstSync_n,
  input  wire logic              start,
  input  wire logic              stop,
  input  wire logic [2:0]        code,
  input  wire logic [UNIT_W-1:0] unitCycles,
  output logic                   done
);
  typedef struct packed {
    logic              running;
    logic [UNIT_W+6:0] cnt;
  } iovr_tmr_t;

  iovr_tmr_t         s_r;
  iovr_tmr_t         s_nxt;
  logic [UNIT_W+6:0] loadVal;

  // Zero unit is taken as one clock so the delay is never shorter than a cycle
  assign loadVal = ({7'h00, (unitCycles == '0) ? UNIT_W'(1) : unitCycles} << code)
                   - (UNIT_W+7)'(1);
  assign done    = s_r.running && (s_r.cnt == '0);

  always_comb begin
    s_nxt = s_r;
    if (stop) begin
      s_nxt.running = 1'b0;
      s_nxt.cnt     = '0;
    end else if (start) begin
      s_nxt.running = 1'b1;
      s_nxt.cnt     = loadVal;
    end else if (done) begin
      s_nxt.running = 1'b0;
    end else if (s_r.running) begin
      s_nxt.cnt = s_r.cnt - (UNIT_W+7)'(1);
    end
  end

  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  default clocking tcb @(posedge mclk); endclocking
  default disable iff (!rstSync_n);

  a_delay_load: assert property (start && !stop
    |=> s_r.running && s_r.cnt + 1 == ((($past(unitCycles) == '0) ? 1 : $past(unitCycles))
        << $past(code)))
    else $error("Delay timer loaded with wrong count");
endmodule

//--- iovr_fault_response.sv
// Input overvoltage fault reaction: ride-through, shutdown, retries and latch-off
`timescale 1ns/1ps
`include "iovr_params.svh"
module iovr_fault_response #(
  parameter int UNIT_W = 16
) (
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic              cfgWe,
  input  wire logic [7:0]        cfgWrData,
  output logic      [7:0]        cfgRdData,
  input  wire logic [UNIT_W-1:0] timeUnitCycles,
  input  wire logic              ovDetect,
  input  wire logic              outputOn,
  input  wire logic              statusClear,
  input  wire logic              clearFaults,
  input  wire logic              otherFault,
  output logic                   outputEnable,
  output logic                   faultLatched,
  output logic                   retrying,
  output logic      [2:0]        attemptCount
);
  typedef struct packed {
    logic [7:0]          reaction;
    iovr_pkg::iovr_state_t st;
    logic [2:0]          attempts;
  } iovr_core_t;

  iovr_core_t           s_r;
  iovr_core_t           s_nxt;
  logic [1:0]           rstPipe_r;
  logic                 rstSync_n;
  logic                 clrAny;
  logic                 tmrStart;
  logic                 tmrDone;
  iovr_pkg::iovr_resp_t resp;
  logic [2:0]           retryCode;
  logic [2:0]           delayCode;

  // Reset released through two flops
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rstPipe_r <= 2'h0;
    end else begin
      rstPipe_r <= {rstPipe_r[0], 1'b1};
    end
  end
  assign rstSync_n = rstPipe_r[1];

  function automatic logic attemptsLeft(input logic [2:0] code, input logic [2:0] used);
    attemptsLeft = (code == `IOVR_RETRY_FOREVER) || (used < code);
  endfunction

  assign resp      = iovr_pkg::iovr_resp_t'(s_r.reaction[`IOVR_RESP_POS +: 2]);
  assign retryCode = s_r.reaction[`IOVR_RETRY_POS +: 3];
  assign delayCode = s_r.reaction[`IOVR_DELAY_POS +: 3];
  assign clrAny    = statusClear || clearFaults || !outputOn;

  always_comb begin
    s_nxt    = s_r;
    tmrStart = 1'b0;
    if (cfgWe) begin
      s_nxt.reaction = cfgWrData;
    end
    if (clrAny) begin
      s_nxt.st       = iovr_pkg::IOVR_ST_RUN;
      s_nxt.attempts = 3'h0;
    end else if (otherFault && s_r.st != iovr_pkg::IOVR_ST_RUN) begin
      s_nxt.st = iovr_pkg::IOVR_ST_LATCHED;
    end else begin
      unique case (s_r.st)
        iovr_pkg::IOVR_ST_RUN: begin
          if (ovDetect) begin
            unique case (resp)
              iovr_pkg::IOVR_IGNORE: s_nxt.st = iovr_pkg::IOVR_ST_RUN;
              iovr_pkg::IOVR_RIDE: begin
                s_nxt.st = iovr_pkg::IOVR_ST_RIDE;
                tmrStart = 1'b1;
              end
              iovr_pkg::IOVR_RETRY: begin
                if (retryCode == `IOVR_RETRY_NONE) begin
                  s_nxt.st = iovr_pkg::IOVR_ST_LATCHED;
                end else begin
                  s_nxt.st = iovr_pkg::IOVR_ST_OFFWAIT;
                  tmrStart = 1'b1;
                end
              end
              iovr_pkg::IOVR_LATCHOFF: s_nxt.st = iovr_pkg::IOVR_ST_LATCHED;
            endcase
          end
        end
        iovr_pkg::IOVR_ST_RIDE: begin
          if (tmrDone) begin
            if (!ovDetect) begin
              s_nxt.st = iovr_pkg::IOVR_ST_RUN;
            end else if (retryCode == `IOVR_RETRY_NONE) begin
              s_nxt.st = iovr_pkg::IOVR_ST_LATCHED;
            end else begin
              s_nxt.st = iovr_pkg::IOVR_ST_OFFWAIT;
              tmrStart = 1'b1;
            end
          end
        end
        iovr_pkg::IOVR_ST_OFFWAIT: begin
          if (tmrDone) begin
            s_nxt.st = iovr_pkg::IOVR_ST_ATTEMPT;
            tmrStart = 1'b1;
            if (s_r.attempts != 3'h7) begin
              s_nxt.attempts = s_r.attempts + 3'h1;
            end
          end
        end
        iovr_pkg::IOVR_ST_ATTEMPT: begin
          if (ovDetect) begin
            if (attemptsLeft(retryCode, s_r.attempts)) begin
              s_nxt.st = iovr_pkg::IOVR_ST_OFFWAIT;
              // Timer ends this cycle; rearm it or the wait would never finish
              tmrStart = tmrDone;
            end else begin
              s_nxt.st = iovr_pkg::IOVR_ST_LATCHED;
            end
          end else if (tmrDone) begin
            s_nxt.st       = iovr_pkg::IOVR_ST_RUN;
            s_nxt.attempts = 3'h0;
          end
        end
        iovr_pkg::IOVR_ST_LATCHED: s_nxt.st = iovr_pkg::IOVR_ST_LATCHED;
        default: s_nxt.st = iovr_pkg::IOVR_ST_RUN;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      s_r.reaction <= `IOVR_REACTION_RST;
      s_r.st       <= iovr_pkg::IOVR_ST_RUN;
      s_r.attempts <= 3'h0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Timer is stopped on any clear so a later fault starts afresh
  iovr_delay_timer #(
    .UNIT_W(UNIT_W)
  ) u_timer (
    .mclk      (mclk),
    .rstSync_n (rstSync_n),
    .start     (tmrStart),
    .stop      (clrAny || (otherFault && s_r.st != iovr_pkg::IOVR_ST_RUN)),
    .code      (delayCode),
    .unitCycles(timeUnitCycles),
    .done      (tmrDone)
  );

  assign cfgRdData    = s_r.reaction;
  assign outputEnable = outputOn && (s_r.st == iovr_pkg::IOVR_ST_RUN ||
                                     s_r.st == iovr_pkg::IOVR_ST_RIDE ||
                                     s_r.st == iovr_pkg::IOVR_ST_ATTEMPT);
  assign faultLatched = (s_r.st == iovr_pkg::IOVR_ST_LATCHED);
  assign retrying     = (s_r.st == iovr_pkg::IOVR_ST_OFFWAIT ||
                         s_r.st == iovr_pkg::IOVR_ST_ATTEMPT);
  assign attemptCount = s_r.attempts;

  default clocking fcb @(posedge mclk); endclocking
  default disable iff (!rstSync_n);

  wire quiet = !clrAny && !otherFault && !cfgWe;
  wire atRun = (s_r.st == iovr_pkg::IOVR_ST_RUN);

  a_ignore_mode: assert property (atRun && resp == iovr_pkg::IOVR_IGNORE && quiet
    |=> atRun && outputEnable == outputOn)
    else $error("Ignore mode left normal operation");
  a_ride_on: assert property (atRun && ovDetect && resp == iovr_pkg::IOVR_RIDE
    && quiet |=> s_r.st == iovr_pkg::IOVR_ST_RIDE && outputEnable == outputOn)
    else $error("Ride-through did not keep output on");
  a_disable_now: assert property (atRun && ovDetect && resp == iovr_pkg::IOVR_RETRY
    && quiet |=> !outputEnable)
    else $error("Disable and retry did not shut output");
  a_latch_hold: assert property (faultLatched && !clrAny |=> faultLatched && !outputEnable)
    else $error("Latched fault released without a clear");
  a_clear_exit: assert property (clrAny |=> atRun && attemptCount == 3'h0)
    else $error("Clear did not return to normal operation");
  a_no_retry: assert property (atRun && ovDetect && resp == iovr_pkg::IOVR_RETRY
    && quiet && retryCode == `IOVR_RETRY_NONE |=> faultLatched)
    else $error("Zero retry code attempted a restart");
  a_attempt_limit: assert property (s_r.st == iovr_pkg::IOVR_ST_ATTEMPT
    && retryCode != `IOVR_RETRY_FOREVER && !$past(cfgWe) |-> attemptCount <= retryCode)
    else $error("More restart attempts than programmed");
  a_exhausted: assert property (s_r.st == iovr_pkg::IOVR_ST_ATTEMPT && ovDetect && quiet
    && !attemptsLeft(retryCode, attemptCount) |=> faultLatched ##1 (faultLatched || clrAny))
    else $error("Exhausted retries did not latch off");
  a_attempt_spacing: assert property (s_r.st != iovr_pkg::IOVR_ST_ATTEMPT
    ##1 s_r.st == iovr_pkg::IOVR_ST_ATTEMPT |-> $past(tmrDone))
    else $error("Restart attempt started before the delay");
  a_unlimited: assert property (s_r.st == iovr_pkg::IOVR_ST_ATTEMPT && ovDetect && quiet
    && retryCode == `IOVR_RETRY_FOREVER |=> s_r.st == iovr_pkg::IOVR_ST_OFFWAIT)
    else $error("Unlimited retry stopped");
  a_other_stop: assert property (retrying && otherFault && !clrAny |=> faultLatched)
    else $error("Other fault did not stop retrying");

  c_ride_recover: cover property (s_r.st == iovr_pkg::IOVR_ST_RIDE ##1 atRun);
  c_attempt_ok: cover property (s_r.st == iovr_pkg::IOVR_ST_ATTEMPT ##1 atRun && !clrAny);
  c_latched: cover property (retrying ##1 faultLatched);
  c_forever: cover property (retryCode == `IOVR_RETRY_FOREVER && attemptCount == 3'h7);
endmodule

//--- iovr_host.sv
// Host-side model: writes the reaction byte and issues fault clears
`timescale 1ns/1ps
module iovr_host (
  input  wire logic       mclk,
  output logic            cfgWe,
  output logic      [7:0] cfgWrData,
  output logic            statusClear,
  output logic            clearFaults,
  output logic            outputOn
);
  initial begin
    cfgWe = 1'b0;
    cfgWrData = 8'h00;
    statusClear = 1'b0;
    clearFaults = 1'b0;
    outputOn = 1'b1;
  end

  task automatic write(input logic [7:0] v);
    @(negedge mclk);
    cfgWe = 1'b1;
    cfgWrData = v;
    @(negedge mclk);
    cfgWe = 1'b0;
    cfgWrData = ~v;
  endtask

  // Kind 0 status bit, 1 clear-faults command, 2 output off then on
  task automatic clear(input int kind);
    @(negedge mclk);
    statusClear = (kind == 0);
    clearFaults = (kind == 1);
    outputOn = (kind != 2);
    @(negedge mclk);
    statusClear = 1'b0;
    clearFaults = 1'b0;
    outputOn = 1'b1;
  endtask
endmodule

//--- input_overvoltage_fault_response_bench.sv
// Self-checking bench of the input overvoltage fault reaction block
`timescale 1ns/1ps
module input_overvoltage_fault_response_bench;
  logic        mclk, rst_n, cfgWe, statusClear, clearFaults, outputOn;
  logic [7:0]  cfgWrData, cfgRdData;
  logic [15:0] unit;
  logic        ovDetect, otherFault, outputEnable, faultLatched, retrying;
  logic [2:0]  attemptCount;
  int          error_cnt = 0;
  int          tests_run = 0;

  iovr_fault_response i_iovr_fault_response (.mclk(mclk), .rst_n(rst_n), .cfgWe(cfgWe),
    .cfgWrData(cfgWrData), .cfgRdData(cfgRdData), .timeUnitCycles(unit),
    .ovDetect(ovDetect), .outputOn(outputOn), .statusClear(statusClear),
    .clearFaults(clearFaults), .otherFault(otherFault), .outputEnable(outputEnable),
    .faultLatched(faultLatched), .retrying(retrying), .attemptCount(attemptCount));
  iovr_host i_iovr_host (.mclk(mclk), .cfgWe(cfgWe), .cfgWrData(cfgWrData),
    .statusClear(statusClear), .clearFaults(clearFaults), .outputOn(outputOn));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      error_cnt++;
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic t_latch;
    for (int k = 0; k < 3; k++) begin
      i_iovr_host.write(8'hc0);
      ovDetect = 1'b1;
      cycles(3);
      chk("latched", 8'h01, {7'h00, faultLatched});
      chk("enable", 8'h00, {7'h00, outputEnable});
      ovDetect = 1'b0;
      cycles(4);
      chk("held", 8'h01, {7'h00, faultLatched});
      i_iovr_host.clear(k);
      cycles(1);
      chk("cleared", 8'h00, {7'h00, faultLatched});
      chk("enable on", 8'h01, {7'h00, outputEnable});
    end
    i_iovr_host.write(8'hc0);
    ovDetect = 1'b1;
    cycles(2);
    ovDetect = 1'b0;
    rst_n = 1'b0;
    cycles(3);
    chk("reset clear", 8'h00, {7'h00, faultLatched});
    chk("reset byte again", 8'h00, cfgRdData);
    rst_n = 1'b1;
    cycles(3);
    $display("latch test done");
  endtask

  task automatic t_retry(input logic [2:0] n, input logic [2:0] code, input logic [15:0] u);
    int gap, sp, i;
    logic [2:0] mx;
    gap = 0;
    sp = 0;
    mx = 3'h0;
    unit = u;
    i_iovr_host.write({2'b10, n, code});
    ovDetect = 1'b1;
    cycles(1);
    chk("shut", 8'h00, {7'h00, outputEnable});
    if (retrying === 1'b1 && attemptCount === 3'h0) gap++;
    for (i = 0; i < 4000 && faultLatched !== 1'b1; i++) begin
      @(negedge mclk);
      if (retrying === 1'b1 && attemptCount === 3'h0) gap++;
      if (retrying === 1'b1 && attemptCount === 3'h1) sp++;
      if (attemptCount > mx) mx = attemptCount;
    end
    if (i == 4000) begin
      $display("MISMATCH retry latch expected 1 seen timeout");
      error_cnt++;
      end_sim();
    end
    chk("attempts", {5'h00, n}, {5'h00, mx});
    if (n != 3'h0) chk("gap", 8'(u << code), 8'(gap));
    if (n > 3'h1) chk("spacing", 8'(u << code), 8'(sp));
    chk("off", 8'h00, {7'h00, outputEnable});
    ovDetect = 1'b0;
    i_iovr_host.clear(1);
    cycles(1);
    chk("count reset", 8'h00, {5'h00, attemptCount});
    $display("retry test done");
  endtask

  task automatic t_ride;
    i_iovr_host.write(8'h40);
    ovDetect = 1'b1;
    cycles(1);
    chk("riding", 8'h01, {retrying, faultLatched, outputEnable});
    ovDetect = 1'b0;
    cycles(8);
    chk("ride on", 8'h01, {7'h00, outputEnable});
    chk("ride normal", 8'h00, {6'h00, retrying, faultLatched});
    ovDetect = 1'b1;
    cycles(3);
    chk("ride hold", 8'h01, {faultLatched, outputEnable});
    cycles(1);
    chk("ride latch", 8'h01, {7'h00, faultLatched});
    ovDetect = 1'b0;
    i_iovr_host.clear(0);
    $display("ride test done");
  endtask

  initial begin
    rst_n = 1'b0;
    unit = 16'h0002;
    ovDetect = 1'b0;
    otherFault = 1'b0;
    cycles(5);
    rst_n = 1'b1;
    cycles(4);
    chk("reset byte", 8'h00, cfgRdData);
    i_iovr_host.write(8'h92);
    chk("readback", 8'h92, cfgRdData);
    i_iovr_host.write(8'h00);
    ovDetect = 1'b1;
    cycles(10);
    chk("ignore", 8'h01, {retrying, faultLatched, outputEnable});
    ovDetect = 1'b0;
    $display("ignore test done");
    t_latch();
    t_retry(3'h0, 3'h0, 16'h0002);
    t_retry(3'h1, 3'h3, 16'h0002);
    t_retry(3'h6, 3'h2, 16'h0003);
    t_ride();
    i_iovr_host.write(8'hb8);
    ovDetect = 1'b1;
    cycles(200);
    chk("forever", 8'h02, {retrying, faultLatched});
    otherFault = 1'b1;
    cycles(2);
    chk("other stop", 8'h01, {7'h00, faultLatched});
    otherFault = 1'b0;
    ovDetect = 1'b0;
    i_iovr_host.clear(2);
    cycles(1);
    chk("restart", 8'h01, {retrying, faultLatched, outputEnable});
    $display("forever test done");
    end_sim();
  end
endmodule
